// ===== uart_loop_pkg.sv
// Constants and types for the loopback and auxiliary output block
package uart_loop_pkg;

  // Printed register offsets are register indices; byte address is four times the index
  localparam logic [7:0] MODEM_CONTROL_IDX = 8'h04;
  localparam logic [7:0] MODEM_STATUS_IDX  = 8'h06;
  localparam logic [7:0] PIN_FUNC_IDX      = 8'h08;
  localparam logic [7:0] IRQ_STATUS_IDX    = 8'h09;
  localparam logic [7:0] IRQ_MASK_IDX      = 8'h0A;
  localparam logic [7:0] MODEM_CONTROL_ADDR = {MODEM_CONTROL_IDX[5:0], 2'b00};
  localparam logic [7:0] MODEM_STATUS_ADDR  = {MODEM_STATUS_IDX[5:0], 2'b00};
  localparam logic [7:0] PIN_FUNC_ADDR      = {PIN_FUNC_IDX[5:0], 2'b00};
  localparam logic [7:0] IRQ_STATUS_ADDR    = {IRQ_STATUS_IDX[5:0], 2'b00};
  localparam logic [7:0] IRQ_MASK_ADDR      = {IRQ_MASK_IDX[5:0], 2'b00};

  // Modem control register fields
  localparam int unsigned CTL_DTR_BIT  = 0;
  localparam int unsigned CTL_RTS_BIT  = 1;
  localparam int unsigned CTL_AUXA_BIT = 2;
  localparam int unsigned CTL_AUXB_BIT = 3;
  localparam int unsigned CTL_LOOP_BIT = 4;
  localparam logic [7:0]  MODEM_CONTROL_RESET = 8'h00;

  // Modem input vector order, also modem status layout (deltas low, levels high)
  localparam int unsigned MDM_CTS = 0;
  localparam int unsigned MDM_DSR = 1;
  localparam int unsigned MDM_RI  = 2;
  localparam int unsigned MDM_DCD = 3;
  localparam int unsigned MDM_W   = 4;
  localparam logic [3:0]  MDM_FALL_ONLY = 4'h4;  // Ring indicator reports trailing edge

  // Interrupt status and mask layout
  localparam int unsigned IRQ_RX_BIT    = 0;
  localparam int unsigned IRQ_TX_BIT    = 1;
  localparam int unsigned IRQ_MODEM_BIT = 2;
  localparam int unsigned IRQ_W         = 3;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;

  // Shared auxiliary pin function select
  typedef enum logic [1:0] {
    PIN_AUX    = 2'h0,
    PIN_BAUD   = 2'h1,
    PIN_RX_DMA = 2'h2
  } pin_func_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

endpackage

// ===== modem_change_detect.sv
// Per-bit change detector for the modem status inputs
`timescale 1ns/1ps
module modem_change_detect
  import uart_loop_pkg::*;
#(
  parameter int unsigned W         = MDM_W,
  parameter logic [W-1:0] FALL_ONLY = MDM_FALL_ONLY
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] state_i,
  output logic      [W-1:0] delta_o
);

  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;

  // Previous sample; reset to deasserted so idle pins do not flag after reset
  always_comb begin
    prev_next = state_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // Selected bits report only a falling edge, the rest any change
  for (genvar g = 0; g < W; g++) begin : g_bit
    assign delta_o[g] = FALL_ONLY[g] ? (prev_reg[g] & ~state_i[g])
                                     : (prev_reg[g] ^ state_i[g]);
  end

endmodule

// ===== uart_loopback_aux_output_ctrl.sv
// Modem control loopback, modem outputs and shared auxiliary pin with AXI4-Lite registers
//
// Functional notes
// [RL1] Loopback holds the serial transmit pin at marking level one.
// [RL2] Loopback ignores receive pin; transmit shifter output feeds the receive shifter.
// [RL3] Loopback disconnects four modem inputs and routes the four control outputs onto them.
// [RL4] Loopback drives all modem control output pins inactive high regardless of bits; aux b is forced high only with PIN_AUX, baud and DMA still drive it.
// [RL5] Receiver and transmitter interrupts keep working in loopback, gated by enables.
// [RL6] Loopback modem status interrupts come from low four control register bits.
// [RL7] Loopback bit resets clear; cleared means normal transmit and receive.
// [RL8] Auxiliary output b pin is low when bit 3 is one; bit resets zero.
// [RL9] Auxiliary pin shared with baud clock and receive DMA ready; reset selects auxiliary.
// [RL10] In loopback auxiliary output a bit drives ring indicator status bit 6.
// [RL11] RTS pin low when bit 1 is one, high otherwise; bit resets zero.
// [RL12] Loopback map: DTR to DSR, RTS to CTS, aux a to RI, aux b to DCD.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module uart_loopback_aux_output_ctrl
  import uart_loop_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_shift_out_i,
  input  wire logic        rx_event_i,
  input  wire logic        tx_event_i,
  input  wire logic        baud_clock_output_i,
  input  wire logic        rx_dma_request_i,
  input  wire logic        serial_rx_pin_i,
  input  wire logic        cts_n_i,
  input  wire logic        dsr_n_i,
  input  wire logic        ri_n_i,
  input  wire logic        dcd_n_i,
  output logic             serial_tx_pin_o,
  output logic             rx_shift_in_o,
  output logic             dtr_n_o,
  output logic             rts_n_o,
  output logic             aux_output_b_o,
  output logic             irq_o
);

  // Pin synchronisers: first stage feeds only the second
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_meta_reg <= 5'h1F;
      pin_sync_reg <= 5'h1F;
    end else begin
      pin_meta_reg <= {serial_rx_pin_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Register state
  logic [7:0]       modem_control_reg, modem_control_next;
  pin_func_t        pin_func_reg, pin_func_next;
  logic [IRQ_W-1:0] irq_status_reg, irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [MDM_W-1:0] modem_delta_reg, modem_delta_next;
  logic             loop_en;
  logic [MDM_W-1:0] modem_state;
  logic [MDM_W-1:0] modem_delta;

  assign loop_en = modem_control_reg[CTL_LOOP_BIT];

  // Asserted-high modem inputs: pins in normal mode, control bits in loopback
  always_comb begin
    if (loop_en) begin
      modem_state[MDM_DSR] = modem_control_reg[CTL_DTR_BIT];  // RL3 RL12
      modem_state[MDM_CTS] = modem_control_reg[CTL_RTS_BIT];  // RL12
      modem_state[MDM_RI]  = modem_control_reg[CTL_AUXA_BIT]; // RL10 RL12
      modem_state[MDM_DCD] = modem_control_reg[CTL_AUXB_BIT]; // RL12
    end else begin
      modem_state = ~pin_sync_reg[MDM_W-1:0];
    end
  end

  // Change detection follows whichever source is selected
  modem_change_detect #(
    .W         (MDM_W),
    .FALL_ONLY (MDM_FALL_ONLY)
  ) u_change (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .state_i (modem_state),
    .delta_o (modem_delta)  // RL6
  );

  // Pin drivers are registered so the pins never glitch on a mode change
  logic serial_tx_reg, rx_shift_reg, dtr_n_reg, rts_n_reg, aux_b_reg;
  logic serial_tx_next, rx_shift_next, dtr_n_next, rts_n_next, aux_b_next;
  always_comb begin
    serial_tx_next = loop_en ? 1'b1 : tx_shift_out_i;                    // RL1 RL7
    rx_shift_next  = loop_en ? tx_shift_out_i : pin_sync_reg[MDM_W];     // RL2
    dtr_n_next     = loop_en | ~modem_control_reg[CTL_DTR_BIT];          // RL4
    rts_n_next     = loop_en | ~modem_control_reg[CTL_RTS_BIT];          // RL4 RL11
    case (pin_func_reg)                                                  // RL9
      PIN_AUX:    aux_b_next = loop_en | ~modem_control_reg[CTL_AUXB_BIT]; // RL4 RL8
      PIN_BAUD:   aux_b_next = baud_clock_output_i;
      PIN_RX_DMA: aux_b_next = rx_dma_request_i;
      default:    aux_b_next = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      serial_tx_reg <= 1'b1;
      rx_shift_reg  <= 1'b1;
      dtr_n_reg     <= 1'b1;
      rts_n_reg     <= 1'b1;
      aux_b_reg     <= 1'b1;
    end else begin
      serial_tx_reg <= serial_tx_next;
      rx_shift_reg  <= rx_shift_next;
      dtr_n_reg     <= dtr_n_next;
      rts_n_reg     <= rts_n_next;
      aux_b_reg     <= aux_b_next;
    end
  end

  assign serial_tx_pin_o = serial_tx_reg;
  assign rx_shift_in_o   = rx_shift_reg;
  assign dtr_n_o         = dtr_n_reg;
  assign rts_n_o         = rts_n_reg;
  assign aux_output_b_o  = aux_b_reg;

  // AXI4-Lite write channel: address and data taken in either order
  wr_state_t   wr_state_reg, wr_state_next;
  logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic [7:0]  w_data_reg, w_data_next;
  logic        w_lane_reg, w_lane_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        wr_do;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_lane;
  logic        wr_hit;

  assign s_axi_awready = (wr_state_reg == WR_IDLE) & ~aw_have_reg;
  assign s_axi_wready  = (wr_state_reg == WR_IDLE) & ~w_have_reg;
  assign s_axi_bvalid  = (wr_state_reg == WR_RESP);
  assign s_axi_bresp   = bresp_reg;
  assign wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_have_reg ? w_data_reg : s_axi_wdata[7:0];
  assign wr_lane = w_have_reg ? w_lane_reg : s_axi_wstrb[0];
  assign wr_do   = (wr_state_reg == WR_IDLE)
                 & (aw_have_reg | s_axi_awvalid) & (w_have_reg | s_axi_wvalid);
  assign wr_hit  = (wr_addr == MODEM_CONTROL_ADDR) | (wr_addr == PIN_FUNC_ADDR)
                 | (wr_addr == IRQ_MASK_ADDR) | (wr_addr == IRQ_STATUS_ADDR)
                 | (wr_addr == MODEM_STATUS_ADDR);

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_have_next  = aw_have_reg;
    w_have_next   = w_have_reg;
    aw_addr_next  = aw_addr_reg;
    w_data_next   = w_data_reg;
    w_lane_next   = w_lane_reg;
    bresp_next    = bresp_reg;
    case (wr_state_reg)
      WR_IDLE: begin
        if (wr_do) begin
          aw_have_next  = 1'b0;
          w_have_next   = 1'b0;
          bresp_next    = wr_hit ? RESP_OKAY : RESP_SLVERR;
          wr_state_next = WR_RESP;
        end else begin
          if (s_axi_awvalid & ~aw_have_reg) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
          end
          if (s_axi_wvalid & ~w_have_reg) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata[7:0];
            w_lane_next = s_axi_wstrb[0];
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = WR_IDLE;
        end
      end
      default: wr_state_next = WR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_state_reg <= WR_IDLE;
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 8'h00;
      w_lane_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_have_reg  <= aw_have_next;
      w_have_reg   <= w_have_next;
      aw_addr_reg  <= aw_addr_next;
      w_data_reg   <= w_data_next;
      w_lane_reg   <= w_lane_next;
      bresp_reg    <= bresp_next;
    end
  end

  // AXI4-Lite read channel: data registered, one cycle after the address is taken
  rd_state_t   rd_state_reg, rd_state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        rd_take;

  assign s_axi_arready = (rd_state_reg == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_reg == RD_DATA);
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_take       = s_axi_arvalid & (rd_state_reg == RD_IDLE);

  always_comb begin
    rd_state_next = rd_state_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_state_next = RD_DATA;
          rresp_next    = RESP_OKAY;
          case (s_axi_araddr)
            MODEM_CONTROL_ADDR: rdata_next = {24'h000000, modem_control_reg};
            MODEM_STATUS_ADDR:  rdata_next = {24'h000000, modem_state, modem_delta_reg};
            PIN_FUNC_ADDR:      rdata_next = {30'h00000000, pin_func_reg};
            IRQ_STATUS_ADDR:    rdata_next = {29'h00000000, irq_status_reg};
            IRQ_MASK_ADDR:      rdata_next = {29'h00000000, irq_mask_reg};
            default: begin
              rdata_next = 32'h00000000;
              rresp_next = RESP_SLVERR;
            end
          endcase
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rd_state_next = RD_IDLE;
        end
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_state_reg <= RD_IDLE;
      rdata_reg    <= 32'h00000000;
      rresp_reg    <= RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
    end
  end

  // Software registers and sticky flags; a new event beats a read-clear in the same cycle
  logic wr_byte;
  assign wr_byte = wr_do & wr_lane;
  always_comb begin
    modem_control_next = modem_control_reg;
    pin_func_next      = pin_func_reg;
    irq_mask_next      = irq_mask_reg;
    modem_delta_next   = modem_delta_reg;
    irq_status_next    = irq_status_reg;
    if (wr_byte && wr_addr == MODEM_CONTROL_ADDR) begin
      modem_control_next = wr_data;
    end
    if (wr_byte && wr_addr == PIN_FUNC_ADDR) begin
      pin_func_next = pin_func_t'(wr_data[1:0]);
    end
    if (wr_byte && wr_addr == IRQ_MASK_ADDR) begin
      irq_mask_next = wr_data[IRQ_W-1:0];
    end
    if (rd_take && s_axi_araddr == MODEM_STATUS_ADDR) begin
      modem_delta_next = '0;
    end
    if (rd_take && s_axi_araddr == IRQ_STATUS_ADDR) begin
      irq_status_next = '0;
    end
    modem_delta_next = modem_delta_next | modem_delta;                   // RL6
    irq_status_next[IRQ_RX_BIT]    = irq_status_next[IRQ_RX_BIT] | rx_event_i; // RL5
    irq_status_next[IRQ_TX_BIT]    = irq_status_next[IRQ_TX_BIT] | tx_event_i; // RL5
    irq_status_next[IRQ_MODEM_BIT] = irq_status_next[IRQ_MODEM_BIT] | (|modem_delta); // RL6
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      modem_control_reg <= MODEM_CONTROL_RESET;  // RL7 RL8 RL11
      pin_func_reg      <= PIN_AUX;              // RL9
      irq_mask_reg      <= IRQ_RESET;
      modem_delta_reg   <= '0;
      irq_status_reg    <= IRQ_RESET;
    end else begin
      modem_control_reg <= modem_control_next;
      pin_func_reg      <= pin_func_next;
      irq_mask_reg      <= irq_mask_next;
      modem_delta_reg   <= modem_delta_next;
      irq_status_reg    <= irq_status_next;
    end
  end

  // Level interrupt: loopback does not gate it, only the mask does
  assign irq_o = |(irq_status_reg & irq_mask_reg);  // RL5

  // Checks
  property p_loop_tx_mark;
    @(posedge clk_i) disable iff (reset_i) loop_en |=> serial_tx_pin_o;
  endproperty
  a_loop_tx_mark: assert property (p_loop_tx_mark) else $error("tx pin not marking"); // RL1

  property p_loop_rx_route;
    @(posedge clk_i) disable iff (reset_i)
      loop_en |=> (rx_shift_in_o == $past(tx_shift_out_i));
  endproperty
  a_loop_rx_route: assert property (p_loop_rx_route) else $error("rx not looped"); // RL2

  property p_loop_map;
    @(posedge clk_i) disable iff (reset_i)
      loop_en |-> (modem_state == {modem_control_reg[CTL_AUXB_BIT],
        modem_control_reg[CTL_AUXA_BIT], modem_control_reg[CTL_DTR_BIT],
        modem_control_reg[CTL_RTS_BIT]});
  endproperty
  a_loop_map: assert property (p_loop_map) else $error("loop map wrong"); // RL3 RL12

  property p_loop_pins_high;
    @(posedge clk_i) disable iff (reset_i) loop_en |=> (dtr_n_o && rts_n_o);
  endproperty
  a_loop_pins_high: assert property (p_loop_pins_high) else $error("pins not high"); // RL4

  property p_rx_irq;
    @(posedge clk_i) disable iff (reset_i)
      (rx_event_i && irq_mask_reg[IRQ_RX_BIT]) ##1 irq_mask_reg[IRQ_RX_BIT] |-> irq_o;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq lost"); // RL5

  property p_loop_modem_irq;
    @(posedge clk_i) disable iff (reset_i)
      (loop_en && $past(loop_en) && $fell(modem_control_reg[CTL_AUXA_BIT]))
        |=> modem_delta_reg[MDM_RI] && irq_status_reg[IRQ_MODEM_BIT];
  endproperty
  a_loop_modem_irq: assert property (p_loop_modem_irq) else $error("no modem delta"); // RL6

  property p_normal_tx;
    @(posedge clk_i) disable iff (reset_i)
      !loop_en |=> (serial_tx_pin_o == $past(tx_shift_out_i));
  endproperty
  a_normal_tx: assert property (p_normal_tx) else $error("tx not passed"); // RL7

  property p_aux_b;
    @(posedge clk_i) disable iff (reset_i)
      (!loop_en && pin_func_reg == PIN_AUX)
        |=> (aux_output_b_o == !$past(modem_control_reg[CTL_AUXB_BIT]));
  endproperty
  a_aux_b: assert property (p_aux_b) else $error("aux b level wrong"); // RL8

  property p_reset_func;
    @(posedge clk_i) reset_i |=> (pin_func_reg == PIN_AUX && !loop_en);
  endproperty
  a_reset_func: assert property (p_reset_func) else $error("bad reset function"); // RL9

  // Checks the status word that software reads, not the internal routing
  property p_ri_bit;
    @(posedge clk_i) disable iff (reset_i)
      (rd_take && loop_en && s_axi_araddr == MODEM_STATUS_ADDR)
        |=> (s_axi_rdata[MDM_W + MDM_RI] == $past(modem_control_reg[CTL_AUXA_BIT]));
  endproperty
  a_ri_bit: assert property (p_ri_bit) else $error("ri not from aux a"); // RL10

  property p_rts;
    @(posedge clk_i) disable iff (reset_i)
      !loop_en |=> (rts_n_o == !$past(modem_control_reg[CTL_RTS_BIT]));
  endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong"); // RL11

  c_loop_on: cover property (@(posedge clk_i) disable iff (reset_i) $rose(loop_en));
  c_write: cover property (@(posedge clk_i) disable iff (reset_i) wr_do ##1 s_axi_bvalid);
  c_irq: cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));
  c_read: cover property (@(posedge clk_i) disable iff (reset_i)
    rd_take && s_axi_araddr == MODEM_STATUS_ADDR);

endmodule

// ===== modem_peer.sv
// Behavioural modem peer facing the handshake and serial receive pins
`timescale 1ns/1ps
module modem_peer (
  input  wire logic       clk_i,
  input  wire logic       rts_n_i,
  input  wire logic       slow_i,
  input  wire logic [2:0] line_i,
  input  wire logic       data_i,
  output logic            cts_n_o,
  output logic            dsr_n_o,
  output logic            ri_n_o,
  output logic            dcd_n_o,
  output logic            rx_line_o
);
  logic [3:0] rts_hist_reg = 4'hF;

  // Clear to send answers a send request after one cycle, or four when slow
  always_ff @(posedge clk_i) begin
    rts_hist_reg <= {rts_hist_reg[2:0], rts_n_i};
  end
  assign cts_n_o = slow_i ? rts_hist_reg[3] : rts_hist_reg[0];

  // Other lines follow the bench's commands: bit 0 set, bit 1 ring, bit 2 carrier
  assign {dcd_n_o, ri_n_o, dsr_n_o} = ~line_i;
  assign rx_line_o = data_i;  // Marking level one when idle
endmodule

// ===== tb.sv
// Self-checking bench for the loopback and auxiliary output block
`timescale 1ns/1ps
module tb;
  import uart_loop_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        tx_shift = 1'b1;
  logic        rx_ev = 1'b0;
  logic        tx_ev = 1'b0;
  logic        baud = 1'b0;
  logic        dma = 1'b0;
  logic        slow = 1'b0;
  logic [2:0]  line = 3'h0;
  logic        data = 1'b1;
  logic        rx_pin, cts_n, dsr_n, ri_n, dcd_n;
  logic        serial_tx, rx_shift_in, dtr_n, rts_n, aux_b, irq;
  integer      seed = 16;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];

  always #12.5 clk_i = ~clk_i;

  uart_loopback_aux_output_ctrl i_uart_loopback_aux_output_ctrl (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_shift_out_i(tx_shift), .rx_event_i(rx_ev), .tx_event_i(tx_ev),
    .baud_clock_output_i(baud), .rx_dma_request_i(dma), .serial_rx_pin_i(rx_pin),
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .dcd_n_i(dcd_n),
    .serial_tx_pin_o(serial_tx), .rx_shift_in_o(rx_shift_in), .dtr_n_o(dtr_n),
    .rts_n_o(rts_n), .aux_output_b_o(aux_b), .irq_o(irq)
  );

  modem_peer i_modem_peer (
    .clk_i(clk_i), .rts_n_i(rts_n), .slow_i(slow), .line_i(line), .data_i(data),
    .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n), .rx_line_o(rx_pin)
  );

  function automatic logic rb();
    int v;
    v = $random(seed);
    return v[0];
  endfunction

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task pin(input logic seen, input logic exp);
    chk({33'h0, seen}, {33'h0, exp});
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Address and data are offered together; each is dropped once taken
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
    rq.push_back({r, 24'h0, e});
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Response watcher pairs each handshake with the oldest noted expectation
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rvalid === 1'b1 && rready === 1'b1) chk({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    tick(20);
    reset_i <= 1'b0;
    tick(2);
    pin(dtr_n, 1'b1);
    pin(rts_n, 1'b1);
    pin(aux_b, 1'b1);
    rd(MODEM_CONTROL_ADDR, 8'h00, RESP_OKAY);
    rd(PIN_FUNC_ADDR, 8'h00, RESP_OKAY);
    repeat (4) begin
      tx_shift <= rb();
      tick(3);
      pin(serial_tx, tx_shift);
    end
    $display("test reset done");
    // Slow peer: clear to send lags the request by several cycles
    line <= 3'b001;
    slow <= 1'b1;
    wr(MODEM_CONTROL_ADDR, 8'h0B, RESP_OKAY);
    tick(1);
    pin(dtr_n, 1'b0);
    pin(rts_n, 1'b0);
    pin(aux_b, 1'b0);
    tick(12);
    rd(MODEM_STATUS_ADDR, 8'h33, RESP_OKAY);
    rd(MODEM_STATUS_ADDR, 8'h30, RESP_OKAY);
    repeat (4) begin
      data <= rb();
      tick(5);
      pin(rx_shift_in, data);
    end
    $display("test normal done");
    wr(MODEM_CONTROL_ADDR, 8'h1F, RESP_OKAY);
    line <= 3'b110;  // External lines move but must be ignored
    tick(1);
    pin(serial_tx, 1'b1);
    pin(dtr_n, 1'b1);
    pin(rts_n, 1'b1);
    pin(aux_b, 1'b1);
    tick(6);
    rd(MODEM_STATUS_ADDR, 8'hF8, RESP_OKAY);
    repeat (6) begin
      tx_shift <= rb();
      tick(2);
      pin(rx_shift_in, tx_shift);
      pin(serial_tx, 1'b1);
    end
    wr(MODEM_CONTROL_ADDR, 8'h1B, RESP_OKAY);
    tick(1);
    rd(MODEM_STATUS_ADDR, 8'hB4, RESP_OKAY);
    $display("test loopback done");
    wr(IRQ_MASK_ADDR, 8'h07, RESP_OKAY);
    rx_ev <= 1'b1;
    tx_ev <= 1'b1;
    tick(1);
    rx_ev <= 1'b0;
    tx_ev <= 1'b0;
    tick(1);
    pin(irq, 1'b1);
    rd(IRQ_STATUS_ADDR, 8'h07, RESP_OKAY);
    tick(1);
    pin(irq, 1'b0);
    wr(IRQ_MASK_ADDR, 8'h06, RESP_OKAY);
    rx_ev <= 1'b1;
    tick(1);
    rx_ev <= 1'b0;
    tick(2);
    pin(irq, 1'b0);
    rd(IRQ_STATUS_ADDR, 8'h01, RESP_OKAY);
    $display("test interrupt done");
    wr(MODEM_CONTROL_ADDR, 8'h08, RESP_OKAY);
    tick(1);
    pin(aux_b, 1'b0);
    for (int f = 1; f < 4; f++) begin
      wr(PIN_FUNC_ADDR, 8'(f), RESP_OKAY);
      repeat (4) begin
        baud <= rb();
        dma <= rb();
        tick(3);
        pin(aux_b, (f == 1) ? baud : ((f == 2) ? dma : 1'b1));
      end
    end
    rd(PIN_FUNC_ADDR, 8'h03, RESP_OKAY);
    wr(PIN_FUNC_ADDR, 8'h00, RESP_OKAY);
    tick(1);
    pin(aux_b, 1'b0);
    rd(8'h3C, 8'h00, RESP_SLVERR);
    wr(8'h3C, 8'h55, RESP_SLVERR);
    tick(2);
    $display("test pin function done");
    complete_run();
  end
endmodule
